// file: logic/ndsr_top.sv
// Software reset command interpreter of the serial NAND die
`timescale 1ns/1ps

// Function
// - A reset is a frame of chip select low, eight bits FFh on the data line at rising serial clock, then chip select high.
// - Once accepted the reset period lasts 5 us when idle and 500 us when an internal operation runs.
// - While the reset period runs every incoming command is ignored.
// - Ending the reset leaves the die in its power-on state with every default restored.
// - The read-mode select bit powers up at 0 for continuous read and may be written to 1 for buffer read.
// - The reset opcode is accepted whether this die is active or idle.
// - Accepting the reset aborts any internal operation and drops all volatile settings.
module ndsr_top
#(
    parameter int RST_MIN_CYC = ndsr_pkg::NDSR_RST_MIN_CYC,
    parameter int RST_MAX_CYC = ndsr_pkg::NDSR_RST_MAX_CYC
)
(
    // Core clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst,
    // Serial link pins
    input  wire logic               link_sclk,
    input  wire logic               link_cs_n,
    input  wire logic               link_di,
    // Core side status and read-mode write
    input  wire logic               op_in_progress,
    input  wire logic               die_active,
    input  wire logic               buf_mode_wr,
    input  wire logic               buf_mode_wdata,
    // Core side outputs
    output ndsr_pkg::ndsr_cmd_t     cmd_out,
    output logic                    reset_busy,
    output logic                    op_abort,
    output logic                    buf_mode
);
    import ndsr_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic is_reset_op(input logic [7:0] op);
        is_reset_op = (op == NDSR_RESET_OPCODE);
    endfunction : is_reset_op

    // ==========================================================
    // Link domain: shift in bits on rising serial clock
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] byte_hold_reg;
    logic       byte_tgl_reg;
    logic       long_tgl_reg;

    // Counter clears while deselected, since the clock stops between frames
    always_ff @(posedge link_sclk or posedge link_cs_n)
    begin
        if (link_cs_n)
            bit_cnt_reg <= 4'h0;
        else if (bit_cnt_reg != 4'h9)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end

    // Shift register, MSB first
    always_ff @(posedge link_sclk)
    begin
        shift_reg <= {shift_reg[6:0], link_di};
    end

    // Eighth bit hands the byte over; ninth flags an overlong frame.
    // Core reset clears the toggles too, or they would never leave X;
    // letting go of it is safe since the serial clock rests between frames
    always_ff @(posedge link_sclk or posedge rst)
    begin
        if (rst)
        begin
            byte_hold_reg <= 8'h00;
            byte_tgl_reg  <= 1'b0;
            long_tgl_reg  <= 1'b0;
        end
        else
        begin
            if (!link_cs_n && bit_cnt_reg == 4'(NDSR_OPCODE_BITS - 1))
            begin
                byte_hold_reg <= {shift_reg[6:0], link_di};
                byte_tgl_reg  <= ~byte_tgl_reg;
            end
            if (!link_cs_n && bit_cnt_reg == 4'(NDSR_OPCODE_BITS))
                long_tgl_reg  <= ~long_tgl_reg;
        end
    end

    // ==========================================================
    // Crossing into the core domain, two sync flops and one edge flop each
    logic [2:0] cs_sync_reg;
    logic [2:0] byte_sync_reg;
    logic [2:0] long_sync_reg;

    // Third stage only feeds edge detection; first stage feeds nothing else
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cs_sync_reg   <= 3'h7;
            byte_sync_reg <= 3'h0;
            long_sync_reg <= 3'h0;
        end
        else
        begin
            cs_sync_reg   <= {cs_sync_reg[1:0], link_cs_n};
            byte_sync_reg <= {byte_sync_reg[1:0], byte_tgl_reg};
            long_sync_reg <= {long_sync_reg[1:0], long_tgl_reg};
        end
    end

    logic frame_end;
    logic byte_evt;
    logic long_evt;
    assign frame_end = cs_sync_reg[1] & ~cs_sync_reg[2];
    assign byte_evt  = byte_sync_reg[1] ^ byte_sync_reg[2];
    assign long_evt  = long_sync_reg[1] ^ long_sync_reg[2];

    // ==========================================================
    // Frame bookkeeping: one whole byte and no more
    logic       got_byte_reg;
    logic       overlong_reg;

    // Byte register is stable here: next frame needs eight clocks to touch it
    always_ff @(posedge core_clk)
    begin
        if (rst || frame_end)
        begin
            got_byte_reg <= 1'b0;
            overlong_reg <= 1'b0;
        end
        else
        begin
            if (byte_evt)
                got_byte_reg <= 1'b1;
            if (long_evt)
                overlong_reg <= 1'b1;
        end
    end

    logic accept_reset;
    // Short frames never set the byte flag, so they die here
    // Die activity is deliberately not a term here
    // Busy still high in the first ready cycle, so a reset there is ignored
    assign accept_reset = frame_end && got_byte_reg && !overlong_reg
                       && !byte_evt && !reset_busy
                       && is_reset_op(byte_hold_reg);

    // ==========================================================
    // Reset period state machine
    ndsr_state_t            state_reg;
    logic [NDSR_CNT_W-1:0]  cnt_reg;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_reg <= NDSR_ST_READY;
            cnt_reg   <= '0;
        end
        else
        begin
            case (state_reg)
                NDSR_ST_READY:
                begin
                    if (accept_reset)
                    begin
                        state_reg <= NDSR_ST_RESET;
                        // Length follows the work being cut short
                        cnt_reg   <= op_in_progress
                            ? NDSR_CNT_W'(RST_MAX_CYC - 1)
                            : NDSR_CNT_W'(RST_MIN_CYC - 1);
                    end
                end
                NDSR_ST_RESET:
                begin
                    if (cnt_reg == '0)
                        state_reg <= NDSR_ST_READY;
                    else
                        cnt_reg <= cnt_reg - NDSR_CNT_W'(1);
                end
                default:
                begin
                    state_reg <= NDSR_ST_READY;
                    cnt_reg   <= '0;
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs
    // Busy mirrors the state so core logic can hold off
    always_ff @(posedge core_clk)
    begin
        if (rst)
            reset_busy <= 1'b0;
        else
            reset_busy <= (state_reg == NDSR_ST_RESET) || accept_reset;
    end

    // One pulse tells the array engine to stop
    always_ff @(posedge core_clk)
    begin
        if (rst)
            op_abort <= 1'b0;
        else
            op_abort <= accept_reset && (state_reg == NDSR_ST_READY);
    end

    // Read-mode bit: software write loses to a reset
    always_ff @(posedge core_clk)
    begin
        if (rst)
            buf_mode <= NDSR_BUF_MODE_RST;
        else if (accept_reset)
            buf_mode <= NDSR_BUF_MODE_RST;
        else if (buf_mode_wr && !reset_busy)
            buf_mode <= buf_mode_wdata;
    end

    // Other opcodes pass on only outside the reset period
    always_ff @(posedge core_clk)
    begin
        if (rst)
            cmd_out <= '0;
        else
        begin
            cmd_out.valid  <= byte_evt && !got_byte_reg
                && state_reg == NDSR_ST_READY && die_active
                && !is_reset_op(byte_hold_reg);
            // Held byte is only read once its toggle has crossed
            if (byte_evt)
                cmd_out.opcode <= byte_hold_reg;
        end
    end

endmodule : ndsr_top

// file: logic/ndsr_pkg.sv
// Package of constants and types for the NAND die software reset block
package ndsr_pkg;

    // ==========================================================
    // Opcodes and frame layout
    localparam logic [7:0]  NDSR_RESET_OPCODE = 8'hFF;
    localparam int          NDSR_OPCODE_BITS  = 8;

    // ==========================================================
    // Timing in ns, and the core clock cycle counts derived from it
    localparam int          NDSR_CLK_PERIOD_NS = 8;
    localparam int          NDSR_T_RST_MIN_NS  = 5000;
    localparam int          NDSR_T_RST_MAX_NS  = 500000;
    // Least time rounds up, longest time rounds down
    localparam int          NDSR_RST_MIN_CYC   =
        (NDSR_T_RST_MIN_NS + NDSR_CLK_PERIOD_NS - 1) / NDSR_CLK_PERIOD_NS;
    localparam int          NDSR_RST_MAX_CYC   =
        NDSR_T_RST_MAX_NS / NDSR_CLK_PERIOD_NS;
    localparam int          NDSR_CNT_W         = 17;

    // ==========================================================
    // Reset values
    localparam logic        NDSR_BUF_MODE_RST  = 1'b0;

    // ==========================================================
    // Types
    typedef enum logic [0:0]
    {
        NDSR_ST_READY = 1'b0,
        NDSR_ST_RESET = 1'b1
    } ndsr_state_t;

    // Opcode handed to the rest of the die
    typedef struct packed
    {
        logic       valid;
        logic [7:0] opcode;
    } ndsr_cmd_t;

endpackage : ndsr_pkg

// file: verif/ndsr_assertions.sv
// Port checker for the software reset interpreter
`timescale 1ns/1ps
module ndsr_checker
#(
    parameter int RST_MIN_CYC = 625,
    parameter int RST_MAX_CYC = 62500
)
(
    // Clock and reset
    input wire logic                core_clk,
    input wire logic                rst,
    // Core side
    input wire logic                op_in_progress,
    input wire logic                die_active,
    input wire logic                buf_mode_wr,
    input wire logic                buf_mode_wdata,
    input wire ndsr_pkg::ndsr_cmd_t cmd_out,
    input wire logic                reset_busy,
    input wire logic                op_abort,
    input wire logic                buf_mode
);
    int   busy_reg;
    logic long_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Length of the running period, seen at its falling edge
    always_ff @(posedge core_clk)
        busy_reg <= (rst || !reset_busy) ? 0 : busy_reg + 1;
    // Kept past the abort, since the level may move later
    always_ff @(posedge core_clk)
        if (op_abort) long_reg <= op_in_progress;
    sequence s_accept;
        op_abort ##1 !op_abort;
    endsequence
    a_abort_pulse: assert property (op_abort |-> s_accept)
        else $error("abort pulse too long");
    a_abort_starts: assert property (op_abort |-> $rose(reset_busy))
        else $error("abort outside a fresh period");
    a_busy_mutes: assert property (reset_busy |-> !cmd_out.valid)
        else $error("command forwarded while busy");
    a_abort_clears: assert property (op_abort |-> !buf_mode)
        else $error("read mode kept over reset");
    a_mode_write: assert property (buf_mode_wr && !reset_busy |=>
        op_abort || buf_mode == $past(buf_mode_wdata))
        else $error("read mode write lost");
    a_busy_holds: assert property (reset_busy |=> $stable(buf_mode))
        else $error("read mode changed while busy");
    a_busy_length: assert property ($fell(reset_busy) |-> busy_reg ==
        (long_reg ? RST_MAX_CYC : RST_MIN_CYC) + 1)
        else $error("reset period length wrong");
    a_cmd_gated: assert property (cmd_out.valid |-> ($past(die_active) &&
        cmd_out.opcode != ndsr_pkg::NDSR_RESET_OPCODE) ##1 !cmd_out.valid)
        else $error("bad command forward");
endmodule : ndsr_checker
bind ndsr_top ndsr_checker #(.RST_MIN_CYC(RST_MIN_CYC),
    .RST_MAX_CYC(RST_MAX_CYC)) ndsr_checker_i (.core_clk, .rst,
    .op_in_progress, .die_active, .buf_mode_wr, .buf_mode_wdata,
    .cmd_out, .reset_busy, .op_abort, .buf_mode);

// file: verif/ndsr_host_model.sv
// Behavioural serial host that drives the die's link pins
`timescale 1ns/1ps
module ndsr_host_model
(
    // Serial pins toward the die
    output logic link_sclk,
    output logic link_cs_n,
    output logic link_di
);
    // Deselected, clock parked low
    initial
    begin
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
        link_di = 1'b1;
    end
    // One frame, MSB first; the clock stands still outside it
    // No die select is ever sent, so the quiet time holds
    task automatic send(input logic [15:0] bits, input int n);
        #3 link_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            link_di = bits[i];
            #32 link_sclk = 1'b1;
            #32 link_sclk = 1'b0;
        end
        #32 link_cs_n = 1'b1;
        link_di = ~link_di; // A released line keeps no stale bit
        #45;
    endtask : send
endmodule : ndsr_host_model

// file: verif/ndsr_top_tb_top.sv
// Self-checking bench of the software reset interpreter
`timescale 1ns/1ps
module ndsr_top_tb_top;
    import ndsr_pkg::*;
    localparam int MIN_C = 120;
    localparam int MAX_C = 300;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic link_sclk, link_cs_n, link_di, reset_busy, op_abort, buf_mode;
    logic op_in_progress = 1'b0;
    logic die_active = 1'b0;
    logic buf_mode_wr = 1'b0;
    logic buf_mode_wdata = 1'b0;
    ndsr_cmd_t cmd_out;
    int err_total = 0, checked = 0, aborts = 0, busy = 0, fwd = 0;
    logic [7:0] fwd_op;
    always #4 core_clk = ~core_clk;
    ndsr_top #(.RST_MIN_CYC(MIN_C), .RST_MAX_CYC(MAX_C)) ndsr_top_i (
        .core_clk, .rst, .link_sclk, .link_cs_n, .link_di, .op_in_progress,
        .die_active, .buf_mode_wr, .buf_mode_wdata, .cmd_out, .reset_busy,
        .op_abort, .buf_mode);
    ndsr_host_model ndsr_host_model_i (.link_sclk, .link_cs_n, .link_di);
    // Tally abort and forward pulses and busy cycles so none is missed between checks
    always @(posedge core_clk)
    begin
        aborts += int'(op_abort === 1'b1);
        busy += int'(reset_busy === 1'b1);
        fwd += int'(cmd_out.valid === 1'b1);
        if (cmd_out.valid === 1'b1)
            fwd_op = cmd_out.opcode;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    // Truncated and overlong frames must start nothing
    task automatic t_short();
        aborts = 0;
        ndsr_host_model_i.send(16'h000F, 4);
        ndsr_host_model_i.send(16'h01FF, 9);
        repeat (8) @(negedge core_clk);
        chk(32'(aborts), 32'h0);
        $display("short frames done");
    endtask : t_short
    task automatic t_fwd();
        die_active = 1'b1;
        fwd = 0;
        ndsr_host_model_i.send(16'h00A5, 8);
        repeat (4) @(negedge core_clk);
        chk(32'(fwd), 32'h1);
        chk(32'(fwd_op), 32'hA5);
        $display("forward done");
    endtask : t_fwd
    // Reset, then a command and a write that the busy die must drop
    task automatic t_reset(input logic long_op);
        @(negedge core_clk);
        buf_mode_wr = 1'b1;
        buf_mode_wdata = 1'b1;
        @(negedge core_clk);
        buf_mode_wr = 1'b0;
        chk(32'(buf_mode), 32'h1);
        op_in_progress = long_op;
        die_active = ~long_op;
        aborts = 0;
        busy = 0;
        fwd = 0;
        ndsr_host_model_i.send(16'h00FF, 8);
        ndsr_host_model_i.send(16'h0033, 8);
        @(negedge core_clk);
        buf_mode_wr = 1'b1;
        @(negedge core_clk);
        buf_mode_wr = 1'b0;
        repeat (MAX_C + 8) @(negedge core_clk);
        chk(32'(aborts), 32'h1);
        chk(32'(busy), 32'(long_op ? MAX_C + 1 : MIN_C + 1));
        chk(32'(buf_mode), 32'h0);
        chk(32'(fwd), 32'h0);
        $display("reset test done");
    endtask : t_reset
    initial
    begin
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        chk(32'(buf_mode), 32'h0);
        t_short();
        t_fwd();
        t_reset(1'b0);
        t_reset(1'b1);
        wrap_up();
    end
endmodule : ndsr_top_tb_top
